//--- src/acc_pkg.sv
// constants shared by the converter and comparator control block
// assumes a byte-addressed avalon slave with one 32-bit word per register
package acc_pkg;
	// register indices; the byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h80;
	localparam logic [7:0] CFG_IDX = 8'h9a;
	localparam logic [7:0] RESULT_IDX = 8'h9f;
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;

	// control register fields
	localparam int CTRL_CMP_RESULT = 7;
	localparam int CTRL_CMP_FLAG = 6;
	localparam int CTRL_DONE = 5;
	localparam int CTRL_START = 4;
	localparam int CTRL_INV_SEL = 3;
	localparam int CTRL_CHAN_HI = 1;
	localparam int CTRL_CHAN_LO = 0;

	// configuration register fields
	localparam int CFG_ADC_PWR = 3;
	localparam int CFG_CMP_PWR = 2;
	localparam int CFG_CLK_FAST = 0;

	// reset values
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [1:0] CHAN_RESET = 2'h0;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// conversion length in oscillator cycles; the oscillator is sys_clk
	localparam int SLOW_CYCLES = 384;
	localparam int FAST_CYCLES = 96;
	localparam int CNT_W = 9;

	typedef enum logic {
		ACC_IDLE,
		ACC_CONVERT
	} acc_state_e;
endpackage

//--- src/acc_top.sv
// control logic of an 8-bit converter with a voltage comparator
// assumes the analog core presents a settled code on conv_code at the end
// of the count and a comparator level synchronous to sys_clk
`timescale 1ns/1ps

// What this block does
// - start bit begins conversion, clears itself after
// - done flag set on completion, software clears
// - comparator output change sets change flag
// - bit seven shows live comparator result
// - bit three picks inverting input one/three
// - channel field selects one of four inputs
// - config bit three powers the converter
// - config bit two powers the comparator
// - config bit zero selects 384/96 cycle conversion
// - result register holds latest conversion code
module acc_top #(
	parameter int SLOW_CYCLES = acc_pkg::SLOW_CYCLES,
	parameter int FAST_CYCLES = acc_pkg::FAST_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [acc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] conv_code,
	input wire logic cmp_level,
	output logic adc_power_en,
	output logic compare_power_enable,
	output logic [1:0] channel_select,
	output logic inverting_input_select,
	output logic conv_busy,
	output logic compare_result_bit
);
	// elaboration-time refusal of counts the counter cannot hold
	if (SLOW_CYCLES < 1 || SLOW_CYCLES >= (1 << acc_pkg::CNT_W) ||
		FAST_CYCLES < 1 ||
		FAST_CYCLES >= (1 << acc_pkg::CNT_W)) begin : g_bad_cycles
		$error("conversion cycle counts do not fit the counter");
	end

	localparam logic [acc_pkg::CNT_W-1:0] SLOW_LOAD =
		acc_pkg::CNT_W'(SLOW_CYCLES - 1);
	localparam logic [acc_pkg::CNT_W-1:0] FAST_LOAD =
		acc_pkg::CNT_W'(FAST_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then the answer
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] idx;
	logic wr_fire, wr_ctrl, wr_cfg;
	logic [7:0] wd;

	assign idx = avs_address[acc_pkg::IDX_LSB +: 8];
	assign wd = avs_writedata[7:0];
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_fire = avs_write & ack_r;
	assign wr_ctrl = wr_fire && idx == acc_pkg::CTRL_IDX;
	assign wr_cfg = wr_fire && idx == acc_pkg::CFG_IDX;
	assign avs_readdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// register and conversion state
	acc_pkg::acc_state_e state_r, state_nxt;
	logic [acc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic start_r, start_nxt;
	logic done_r, done_nxt;
	logic cmp_flag_r, cmp_flag_nxt;
	logic cmp_q_r, cmp_q_nxt;
	logic inv_sel_r, inv_sel_nxt;
	logic [1:0] chan_r, chan_nxt;
	logic [7:0] cfg_r, cfg_nxt;
	logic [7:0] result_r, result_nxt;
	logic conv_end, cmp_change;
	logic [7:0] ctrl_view;

	assign conv_end = state_r == acc_pkg::ACC_CONVERT && cnt_r == '0;
	// comparator powered off holds its last level, so no change is flagged
	assign cmp_change = cfg_r[acc_pkg::CFG_CMP_PWR] && cmp_level != cmp_q_r;

	// control register as software sees it; bit two reads zero
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[acc_pkg::CTRL_CMP_RESULT] = cmp_q_r;
		ctrl_view[acc_pkg::CTRL_CMP_FLAG] = cmp_flag_r;
		ctrl_view[acc_pkg::CTRL_DONE] = done_r;
		ctrl_view[acc_pkg::CTRL_START] = start_r;
		ctrl_view[acc_pkg::CTRL_INV_SEL] = inv_sel_r;
		ctrl_view[acc_pkg::CTRL_CHAN_HI] = chan_r[1];
		ctrl_view[acc_pkg::CTRL_CHAN_LO] = chan_r[0];
	end

	// read mux sampled while waitrequest is high; unmapped reads give zero
	always_comb begin
		ack_nxt = (avs_read | avs_write) & ~ack_r;
		rdata_nxt = rdata_r;
		if (avs_read && !ack_r) begin
			case (idx)
				acc_pkg::CTRL_IDX: rdata_nxt = {24'h000000, ctrl_view};
				acc_pkg::CFG_IDX: rdata_nxt = {24'h000000, cfg_r};
				acc_pkg::RESULT_IDX: rdata_nxt = {24'h000000, result_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// next values of registers, flags and the conversion sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		start_nxt = start_r;
		done_nxt = done_r;
		cmp_flag_nxt = cmp_flag_r;
		cmp_q_nxt = cmp_q_r;
		inv_sel_nxt = inv_sel_r;
		chan_nxt = chan_r;
		cfg_nxt = cfg_r;
		result_nxt = result_r;
		if (wr_cfg) begin
			cfg_nxt = 8'h00; // reserved bits stay zero
			cfg_nxt[acc_pkg::CFG_ADC_PWR] = wd[acc_pkg::CFG_ADC_PWR];
			cfg_nxt[acc_pkg::CFG_CMP_PWR] = wd[acc_pkg::CFG_CMP_PWR];
			cfg_nxt[acc_pkg::CFG_CLK_FAST] = wd[acc_pkg::CFG_CLK_FAST];
		end
		if (wr_ctrl) begin
			inv_sel_nxt = wd[acc_pkg::CTRL_INV_SEL];
			chan_nxt = {wd[acc_pkg::CTRL_CHAN_HI],
				wd[acc_pkg::CTRL_CHAN_LO]};
			// flags clear on a written zero only
			if (!wd[acc_pkg::CTRL_DONE])
				done_nxt = 1'b0;
			if (!wd[acc_pkg::CTRL_CMP_FLAG])
				cmp_flag_nxt = 1'b0;
		end
		// comparator level tracked only while powered
		if (cfg_r[acc_pkg::CFG_CMP_PWR])
			cmp_q_nxt = cmp_level;
		if (cmp_change)
			cmp_flag_nxt = 1'b1;
		case (state_r)
			acc_pkg::ACC_IDLE: begin
				// a start while powered down is dropped, the core is asleep
				if (wr_ctrl && wd[acc_pkg::CTRL_START] &&
					cfg_r[acc_pkg::CFG_ADC_PWR]) begin
					start_nxt = 1'b1;
					state_nxt = acc_pkg::ACC_CONVERT;
					cnt_nxt = cfg_r[acc_pkg::CFG_CLK_FAST] ?
						FAST_LOAD : SLOW_LOAD;
				end
			end
			acc_pkg::ACC_CONVERT: begin
				// writes to the start bit cannot abort a running conversion
				if (conv_end) begin
					start_nxt = 1'b0;
					done_nxt = 1'b1;
					result_nxt = conv_code;
					state_nxt = acc_pkg::ACC_IDLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				state_nxt = acc_pkg::ACC_IDLE;
				start_nxt = 1'b0;
			end
		endcase
	end

	// registering only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h00000000;
			state_r <= acc_pkg::ACC_IDLE;
			cnt_r <= '0;
			start_r <= 1'b0;
			done_r <= 1'b0;
			cmp_flag_r <= 1'b0;
			cmp_q_r <= 1'b0;
			inv_sel_r <= 1'b0;
			chan_r <= acc_pkg::CHAN_RESET;
			cfg_r <= acc_pkg::CFG_RESET;
			result_r <= acc_pkg::RESULT_RESET;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			start_r <= start_nxt;
			done_r <= done_nxt;
			cmp_flag_r <= cmp_flag_nxt;
			cmp_q_r <= cmp_q_nxt;
			inv_sel_r <= inv_sel_nxt;
			chan_r <= chan_nxt;
			cfg_r <= cfg_nxt;
			result_r <= result_nxt;
		end
	end

	// analog-facing controls straight from registers
	assign adc_power_en = cfg_r[acc_pkg::CFG_ADC_PWR];
	assign compare_power_enable = cfg_r[acc_pkg::CFG_CMP_PWR];
	assign channel_select = chan_r;
	assign inverting_input_select = inv_sel_r;
	assign conv_busy = state_r == acc_pkg::ACC_CONVERT;
	assign compare_result_bit = cmp_q_r;

	////////////////////////////////////////////////////////////////////////
	// check helpers: length of each busy run and the clock select taken
	// at its start; counters keep long lengths out of repetitions
	localparam logic [acc_pkg::CNT_W:0] FAST_LEN =
		(acc_pkg::CNT_W + 1)'(FAST_CYCLES);
	localparam logic [acc_pkg::CNT_W:0] SLOW_LEN =
		(acc_pkg::CNT_W + 1)'(SLOW_CYCLES);
	logic [acc_pkg::CNT_W:0] busy_len_r, busy_len_nxt;
	logic run_fast_r, run_fast_nxt;

	// next values; the run length counts conv_busy, the clock select is taken from the bus side
	always_comb begin
		busy_len_nxt = conv_busy ? busy_len_r + 1'b1 : '0;
		run_fast_nxt = run_fast_r;
		// a later config write must not change the expected length
		if (wr_ctrl && wd[acc_pkg::CTRL_START] && !conv_busy)
			run_fast_nxt = cfg_r[acc_pkg::CFG_CLK_FAST];
	end

	// registering only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_len_r <= '0;
			run_fast_r <= 1'b0;
		end else begin
			busy_len_r <= busy_len_nxt;
			run_fast_r <= run_fast_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_START_SELF_CLEAR: assert property (
		conv_end |=> !start_r && !conv_busy)
		else $error("start bit not cleared at end of conversion");
	AST_DONE_SET: assert property (
		conv_end |=> done_r && result_r == $past(conv_code))
		else $error("done flag or result missing after conversion");
	AST_DONE_STICKY: assert property (
		done_r && !(wr_ctrl && !wd[acc_pkg::CTRL_DONE]) |=> done_r)
		else $error("done flag dropped without a software clear");
	AST_CMP_CHANGE: assert property (
		cmp_change |=> cmp_flag_r)
		else $error("comparator change not flagged");
	AST_CMP_LIVE: assert property (
		$past(compare_power_enable) |-> compare_result_bit ==
			$past(cmp_level))
		else $error("comparator result bit not following input");
	AST_INV_SEL: assert property (
		wr_ctrl |=> inverting_input_select ==
			$past(wd[acc_pkg::CTRL_INV_SEL]))
		else $error("inverting input select not written");
	AST_CHAN_SEL: assert property (
		wr_ctrl |=> channel_select == $past({wd[acc_pkg::CTRL_CHAN_HI],
			wd[acc_pkg::CTRL_CHAN_LO]}))
		else $error("channel select not written");
	AST_POWER: assert property (
		wr_cfg |=> adc_power_en == $past(wd[acc_pkg::CFG_ADC_PWR]) &&
			compare_power_enable == $past(wd[acc_pkg::CFG_CMP_PWR]))
		else $error("power enables not written");
	AST_FAST_LEN: assert property (
		$fell(conv_busy) && run_fast_r |-> busy_len_r == FAST_LEN)
		else $error("fast conversion length wrong");
	AST_SLOW_LEN: assert property (
		$fell(conv_busy) && !run_fast_r |-> busy_len_r == SLOW_LEN)
		else $error("slow conversion length wrong");
	AST_END_TOGETHER: assert property (
		$fell(start_r) |-> done_r && $fell(conv_busy))
		else $error("start cleared apart from done flag");
	// an accepted start begins a run at once
	AST_START_ACCEPT: assert property (
		wr_ctrl && wd[acc_pkg::CTRL_START] && adc_power_en &&
			!conv_busy |=> conv_busy && start_r)
		else $error("start write did not begin a conversion");
	// the result only moves at the end of a conversion
	AST_RESULT_HOLD: assert property (
		!conv_end |=> result_r == $past(result_r))
		else $error("result changed outside conversion end");
	AST_BUS_ANSWER: assert property (
		avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer later than one wait cycle");

	COV_FAST: cover property (
		$rose(conv_busy) && cfg_r[acc_pkg::CFG_CLK_FAST]);
	COV_SLOW_END: cover property (
		conv_end && !cfg_r[acc_pkg::CFG_CLK_FAST]);
	COV_CMP_FLAG: cover property ($rose(cmp_flag_r));
	COV_CLEAR_RACE: cover property (
		cmp_change && wr_ctrl && !wd[acc_pkg::CTRL_CMP_FLAG]);
endmodule // acc_top

//--- verif/acc_analog_model.sv
// behavioural analog core: four fixed input levels, converter and comparator
// assumes the control block drives channel, inverting select and power pins
`timescale 1ns/1ps

module acc_analog_model #(
	parameter logic [31:0] LEVELS = 32'hc0804010
) (
	input wire logic sys_clk,
	input wire logic [1:0] channel_select,
	input wire logic inverting_input_select,
	input wire logic adc_power_en,
	input wire logic compare_power_enable,
	output logic [7:0] conv_code,
	output logic cmp_level
);
	logic toggle_r = 1'b0;
	logic [7:0] pos_lvl;
	logic [7:0] neg_lvl;

	////////////////////////////////////////////////////////////////////////
	// unpowered outputs wiggle so a stale value cannot pass for a result
	always @(posedge sys_clk) begin
		toggle_r <= ~toggle_r;
	end

	// selected input feeds converter and positive comparator leg
	// pins taken as undriven high-impedance inputs, so levels are ideal
	assign pos_lvl = LEVELS[channel_select*8 +: 8];
	assign neg_lvl = inverting_input_select ?
		LEVELS[31:24] : LEVELS[15:8];
	assign conv_code = adc_power_en ? pos_lvl : {8{toggle_r}};
	assign cmp_level = compare_power_enable ?
		(pos_lvl > neg_lvl) : toggle_r;
endmodule // acc_analog_model

//--- verif/acc_top_bench.sv
// self-checking bench: avalon register tasks driving conversions and compares
// assumes acc_top and acc_analog_model; counts shortened by parameters
`timescale 1ns/1ps

module acc_top_bench;
	localparam int SLOW_N = 20;
	localparam int FAST_N = 6;
	localparam logic [31:0] LVL = 32'hc0804010;
	localparam logic [9:0] A_CTRL = {acc_pkg::CTRL_IDX, 2'b00};
	localparam logic [9:0] A_CFG = {acc_pkg::CFG_IDX, 2'b00};
	localparam logic [9:0] A_RES = {acc_pkg::RESULT_IDX, 2'b00};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] conv_code;
	logic cmp_level;
	logic adc_power_en;
	logic compare_power_enable;
	logic [1:0] channel_select;
	logic inverting_input_select;
	logic conv_busy;
	logic compare_result_bit;
	logic [31:0] rd;
	int mismatches = 0;
	int tests_run = 0;
	int n;

	////////////////////////////////////////////////////////////////////////
	always #25 sys_clk = ~sys_clk;

	acc_top #(.SLOW_CYCLES(SLOW_N), .FAST_CYCLES(FAST_N)) acc_top_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .conv_code(conv_code),
		.cmp_level(cmp_level), .adc_power_en(adc_power_en),
		.compare_power_enable(compare_power_enable),
		.channel_select(channel_select),
		.inverting_input_select(inverting_input_select),
		.conv_busy(conv_busy), .compare_result_bit(compare_result_bit));

	acc_analog_model #(.LEVELS(LVL)) acc_analog_model_i (
		.sys_clk(sys_clk), .channel_select(channel_select),
		.inverting_input_select(inverting_input_select),
		.adc_power_en(adc_power_en),
		.compare_power_enable(compare_power_enable),
		.conv_code(conv_code), .cmp_level(cmp_level));

	////////////////////////////////////////////////////////////////////////
	// verdict and end of run, also reached by any exhausted wait
	task automatic stop_test();
		$display("counts: run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one avalon transfer; request held until waitrequest samples low
	task automatic bus(input logic wr, input logic [9:0] a,
		input logic [31:0] wd, output logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 50) begin
			mismatches++;
			stop_test();
		end
	endtask

	// cycles with busy high after the start write lands
	task automatic wait_conv(output int c);
		c = 0;
		do begin
			@(posedge sys_clk);
			#1 c++;
		end while (conv_busy === 1'b1 && c < 1000);
		if (c >= 1000) begin
			mismatches++;
			stop_test();
		end
	endtask

	// comparator step: write control, let levels settle, read it back
	task automatic cmp_step(input logic [7:0] w, input logic [7:0] exp);
		bus(1'b1, A_CTRL, {24'h0, w}, rd);
		repeat (4) @(posedge sys_clk);
		bus(1'b0, A_CTRL, 32'h0, rd);
		check(rd, {24'h0, exp});
		check({31'h0, compare_result_bit},
			{31'h0, exp[acc_pkg::CTRL_CMP_RESULT]});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b0, A_CFG, 32'h0, rd);
		check(rd, {24'h0, acc_pkg::CFG_RESET});
		bus(1'b0, 10'h004, 32'h0, rd);
		check(rd, 32'h0);
		bus(1'b1, A_CTRL, 32'h10, rd);
		bus(1'b0, A_CTRL, 32'h0, rd);
		check(rd, 32'h0);
		$display("test reset and power-off start done");
		bus(1'b1, A_CFG, 32'h09, rd);
		@(posedge sys_clk);
		check({31'h0, adc_power_en}, 32'h1);
		for (int ch = 0; ch < 4; ch++) begin
			bus(1'b1, A_CTRL, 32'h10 | ch, rd);
			wait_conv(n);
			check(n, FAST_N);
			check({30'h0, channel_select}, ch);
			bus(1'b0, A_CTRL, 32'h0, rd);
			check(rd, 32'h20 | ch);
			bus(1'b0, A_RES, 32'h0, rd);
			check(rd, {24'h0, LVL[ch*8 +: 8]});
		end
		$display("test fast conversions done");
		bus(1'b1, A_CFG, 32'h08, rd);
		bus(1'b1, A_CTRL, 32'h31, rd);
		wait_conv(n);
		check(n, SLOW_N);
		bus(1'b0, A_CTRL, 32'h0, rd);
		check(rd, 32'h21);
		bus(1'b1, A_CTRL, 32'h01, rd);
		bus(1'b0, A_CTRL, 32'h0, rd);
		check(rd, 32'h01);
		$display("test slow conversion and flag clear done");
		bus(1'b1, A_CFG, 32'h0c, rd);
		@(posedge sys_clk);
		check({31'h0, compare_power_enable}, 32'h1);
		cmp_step(8'h00, 8'h00);
		cmp_step(8'h02, 8'hc2);
		cmp_step(8'h0a, 8'h4a);
		cmp_step(8'h0a, 8'h0a);
		check({31'h0, inverting_input_select}, 32'h1);
		$display("test comparator done");
		stop_test();
	end
endmodule // acc_top_bench
